// ==== hdl/sadc_defs.svh ====
// register map, field positions, reset values and timing counts of the sequencer
//
// Functional notes
// - conversion clock CPU over four; 12 periods
// - capacitor released, then eight one-bit approximation steps
// - sample and convert phases repeat without pause
// - input at upper reference gives ffh, no flag
// - input at lower reference gives 00h; monotonic
// - setting on bit starts conversions immediately, continuously
// - completion sets bit 7, never an interrupt
// - result holds until the next conversion ends
// - control write with on aborts and restarts
// - result read or control write clears completion
// - bit 5 switches converter off or on
// - bits 3:0 pick one of sixteen inputs
// - wait has no effect; halt disables, then settles
// - both registers reset to 00h
`ifndef SADC_DEFS_SVH
`define SADC_DEFS_SVH

// ----------------------------------------------------------------------
// register bus
// ----------------------------------------------------------------------
`define SADC_ADDR_W          4
`define SADC_RESULT_IDX      4'h0
`define SADC_CSR_IDX         4'h1
`define SADC_EVT_STATUS_IDX  4'h2
`define SADC_EVT_MASK_IDX    4'h3

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define SADC_CSR_COCO_BIT    7
`define SADC_CSR_ON_BIT      5
`define SADC_CSR_SEL_MSB     3
`define SADC_CSR_SEL_LSB     0
`define SADC_CSR_RESET       8'h00
`define SADC_RESULT_RESET    8'h00
`define SADC_MASK_RESET      8'h00
`define SADC_EVT_OVERRUN_BIT 0
`define SADC_EVT_ABORT_BIT   1
`define SADC_SAR_FIRST       8'h80

// ----------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------
`define SADC_CLK_DIV         4
`define SADC_CONV_PERIODS    12
`define SADC_SAR_BITS        8
`define SADC_STAB_PERIODS    16

`endif

// ==== hdl/sadc_pkg.sv ====
// types shared by the sequencer modules
package sadc_pkg;
   // sequencer phases, one-hot
   typedef enum logic [3:0] {
      SADC_OFF     = 4'b0001,
      SADC_SAMPLE  = 4'b0010,
      SADC_CONVERT = 4'b0100,
      SADC_SETTLE  = 4'b1000
   } sadc_state_type;
endpackage

// ==== hdl/sadc_clk_div.sv ====
// conversion clock enable: one tick every DIV_RATIO system clocks
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_clk_div #(
   parameter int unsigned DIV_RATIO = `SADC_CLK_DIV
) (
   input  wire logic sys_clk,  // system clock
   input  wire logic rstn,     // async reset, active low
   input  wire logic ce,       // clock enable
   input  wire logic restart,  // realign the period to this edge
   output logic      tick      // last clock of a conversion period
);
   localparam int CW = (DIV_RATIO > 1) ? $clog2(DIV_RATIO) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV_RATIO - 1);

   logic [CW-1:0] cnt;

   generate
      if (DIV_RATIO < 2) begin : g_bad_div
         $error("sadc_clk_div: DIV_RATIO must be at least 2");
      end
   endgenerate

   // free-running prescaler, restarted so a fresh conversion gets whole periods
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= '0;
      end else if (ce) begin
         if (restart || cnt == LAST) begin
            cnt <= '0;
         end else begin
            cnt <= cnt + CW'(1);
         end
      end
   end

   assign tick = (cnt == LAST);
endmodule

// ==== hdl/sadc_sar.sv ====
// successive-approximation register: trial code and bit mask
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_sar (
   input  wire logic       sys_clk,   // system clock
   input  wire logic       rstn,      // async reset, active low
   input  wire logic       ce,        // clock enable
   input  wire logic       clear,     // load the mid-scale trial
   input  wire logic       step,      // decide the bit under the mask
   input  wire logic       compGe,    // input at or above the trial code
   output logic      [7:0] trial,     // code offered to the comparator
   output logic      [7:0] resolved   // code once the current bit is decided
);
   logic [7:0] mask;

   // keep the trial bit when the input is not below it
   assign resolved = compGe ? trial : (trial & ~mask);

   // one bit per step, msb first; the next lower bit becomes the new trial
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         trial <= 8'h00;
         mask  <= 8'h00;
      end else if (ce) begin
         if (clear) begin
            trial <= `SADC_SAR_FIRST;
            mask  <= `SADC_SAR_FIRST;
         end else if (step) begin
            trial <= resolved | (mask >> 1);
            mask  <= mask >> 1;
         end
      end
   end

   a_sar_mask_onehot : assert property (@(posedge sys_clk) disable iff (!rstn)
      $onehot0(mask))
      else $error("sar mask holds more than one bit");
   a_sar_low_clear : assert property (@(posedge sys_clk) disable iff (!rstn)
      (mask != 8'h00) |-> ((trial & (mask - 8'h01)) == 8'h00))
      else $error("sar bits below the trial bit are not clear");
endmodule

// ==== hdl/sadc_sequencer.sv ====
// 8-bit successive-approximation converter sequencer with register port
`timescale 1ns/10ps
`include "sadc_defs.svh"
module sadc_sequencer
   import sadc_pkg::*;
#(
   parameter int unsigned DIV_RATIO    = `SADC_CLK_DIV,       // system clocks per period
   parameter int unsigned CONV_PERIODS = `SADC_CONV_PERIODS,  // periods per conversion
   parameter int unsigned STAB_PERIODS = `SADC_STAB_PERIODS   // settle periods after halt
) (
   input  wire logic                     sys_clk,          // system clock, 40 MHz
   input  wire logic                     rstn,             // async reset, active low
   input  wire logic                     ce,               // clock enable, freezes all
   input  wire logic [`SADC_ADDR_W-1:0]  regAddr,          // register index
   input  wire logic [7:0]               regWrData,        // write data
   input  wire logic                     regWrStb,         // write strobe
   input  wire logic                     regRdStb,         // read strobe
   output logic      [7:0]               regRdData,        // read data, cycle after strobe
   input  wire logic                     compGe,           // comparator: input >= trial
   input  wire logic                     haltMode,         // processor halt state
   output logic                          sampleEn,         // capacitor tied to input
   output logic      [3:0]               muxSel,           // analog input select
   output logic      [7:0]               dacCode,          // trial code to comparator
   output logic                          converterPowered, // analog part powered
   output logic                          irq               // level interrupt
);
   // ----------------------------------------------------------------------
   // derived counts
   // ----------------------------------------------------------------------
   localparam int unsigned SAR_BITS = `SADC_SAR_BITS;
   localparam int unsigned SMP_PERIODS = CONV_PERIODS - SAR_BITS;
   localparam logic [3:0] SAMPLE_LAST = 4'(SMP_PERIODS - 1);
   localparam logic [3:0] CONVERT_LAST = 4'(SAR_BITS - 1);
   localparam logic [3:0] SETTLE_LAST = 4'(STAB_PERIODS - 1);
   localparam logic [7:0] SMP_CYCLES = 8'(SMP_PERIODS * DIV_RATIO);
   localparam logic [7:0] CNV_LAST_CYC = 8'(SAR_BITS * DIV_RATIO - 1);

   generate
      if (CONV_PERIODS <= SAR_BITS || SMP_PERIODS > 16) begin : g_bad_conv
         $error("sadc_sequencer: CONV_PERIODS must leave 1 to 16 sample periods");
      end
      if (STAB_PERIODS < 1 || STAB_PERIODS > 16) begin : g_bad_stab
         $error("sadc_sequencer: STAB_PERIODS must be 1 to 16");
      end
      if (SAR_BITS * DIV_RATIO > 255 || SMP_PERIODS * DIV_RATIO > 255) begin : g_bad_div
         $error("sadc_sequencer: DIV_RATIO too large");
      end
   endgenerate

   // ----------------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------------
   // address compare, used by both strobes
   function automatic logic hit(input logic stb, input logic [`SADC_ADDR_W-1:0] a,
                                input logic [`SADC_ADDR_W-1:0] idx);
      hit = stb && (a == idx);
   endfunction

   logic wrCsr;
   logic wrMask;
   logic rdResult;
   logic rdStatus;
   logic restartReq;

   assign wrCsr      = hit(regWrStb, regAddr, `SADC_CSR_IDX);
   assign wrMask     = hit(regWrStb, regAddr, `SADC_EVT_MASK_IDX);
   assign rdResult   = hit(regRdStb, regAddr, `SADC_RESULT_IDX);
   assign rdStatus   = hit(regRdStb, regAddr, `SADC_EVT_STATUS_IDX);
   assign restartReq = wrCsr && regWrData[`SADC_CSR_ON_BIT];

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   sadc_state_type state;
   logic [3:0]     phaseCnt;
   logic           converterOn;
   logic [3:0]     inputSelect;
   logic           coco;
   logic [7:0]     result;
   logic [1:0]     evtStatus;
   logic [1:0]     evtMask;
   logic           adcTick;
   logic           lastStep;
   logic           sarClear;
   logic           sarStep;
   logic [7:0]     sarResolved;
   logic           busy;

   // the period tick is realigned by every control write and by halt
   sadc_clk_div #(
      .DIV_RATIO (DIV_RATIO)
   ) u_div (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .ce      (ce),
      .restart (wrCsr || haltMode),
      .tick    (adcTick)
   );

   assign busy     = (state == SADC_SAMPLE) || (state == SADC_CONVERT);
   assign lastStep = (state == SADC_CONVERT) && adcTick && (phaseCnt == CONVERT_LAST)
                     && !haltMode && !wrCsr;
   assign sarClear = (state == SADC_SAMPLE) && adcTick && (phaseCnt == SAMPLE_LAST)
                     && !haltMode && !wrCsr;
   assign sarStep  = (state == SADC_CONVERT) && adcTick && !haltMode && !wrCsr;

   sadc_sar u_sar (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .ce       (ce),
      .clear    (sarClear),
      .step     (sarStep),
      .compGe   (compGe),
      .trial    (dacCode),
      .resolved (sarResolved)
   );

   // ----------------------------------------------------------------------
   // phase sequencer
   // ----------------------------------------------------------------------
   // halt wins, then a control write, then the running sequence
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state    <= SADC_OFF;
         phaseCnt <= 4'h0;
      end else if (ce) begin
         if (haltMode) begin
            state    <= SADC_OFF;
            phaseCnt <= 4'h0;
         end else if (wrCsr) begin
            // on: abort and sample afresh; off: stop at once
            state    <= restartReq ? SADC_SAMPLE : SADC_OFF;
            phaseCnt <= 4'h0;
         end else begin
            unique case (state)
               SADC_OFF: begin
                  // only reached with the bit still on when coming out of halt
                  if (converterOn) begin
                     state    <= SADC_SETTLE;
                     phaseCnt <= 4'h0;
                  end
               end
               SADC_SETTLE: begin
                  if (adcTick) begin
                     if (phaseCnt == SETTLE_LAST) begin
                        state    <= SADC_SAMPLE;
                        phaseCnt <= 4'h0;
                     end else begin
                        phaseCnt <= phaseCnt + 4'h1;
                     end
                  end
               end
               SADC_SAMPLE: begin
                  if (adcTick) begin
                     if (phaseCnt == SAMPLE_LAST) begin
                        state    <= SADC_CONVERT;
                        phaseCnt <= 4'h0;
                     end else begin
                        phaseCnt <= phaseCnt + 4'h1;
                     end
                  end
               end
               SADC_CONVERT: begin
                  if (adcTick) begin
                     if (phaseCnt == CONVERT_LAST) begin
                        state    <= SADC_SAMPLE;
                        phaseCnt <= 4'h0;
                     end else begin
                        phaseCnt <= phaseCnt + 4'h1;
                     end
                  end
               end
               default: begin
                  state    <= SADC_OFF;
                  phaseCnt <= 4'h0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // control/status and result registers
   // ----------------------------------------------------------------------
   // software fields; bits 6 and 4 are not stored and read as zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         converterOn <= 1'(`SADC_CSR_RESET >> `SADC_CSR_ON_BIT);
         inputSelect <= 4'h0;
      end else if (ce && wrCsr) begin
         converterOn <= regWrData[`SADC_CSR_ON_BIT];
         inputSelect <= regWrData[`SADC_CSR_SEL_MSB:`SADC_CSR_SEL_LSB];
      end
   end

   // completion flag: hardware set wins over a result read in the same cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         coco <= 1'b0;
      end else if (ce) begin
         if (lastStep) begin
            coco <= 1'b1;
         end else if (wrCsr || rdResult) begin
            coco <= 1'b0;
         end
      end
   end

   // result only moves at the end of a conversion
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         result <= `SADC_RESULT_RESET;
      end else if (ce && lastStep) begin
         result <= sarResolved;
      end
   end

   // ----------------------------------------------------------------------
   // event status, mask and interrupt
   // ----------------------------------------------------------------------
   // completion is deliberately not an event: only overrun and abort are
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         evtStatus <= 2'b00;
      end else if (ce) begin
         evtStatus[`SADC_EVT_OVERRUN_BIT] <=
            (evtStatus[`SADC_EVT_OVERRUN_BIT] && !rdStatus) ||
            (lastStep && coco && !rdResult);
         evtStatus[`SADC_EVT_ABORT_BIT] <=
            (evtStatus[`SADC_EVT_ABORT_BIT] && !rdStatus) || (wrCsr && busy);
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         evtMask <= 2'(`SADC_MASK_RESET);
      end else if (ce && wrMask) begin
         evtMask <= regWrData[1:0];
      end
   end

   // registered, so it follows the status by one cycle
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(evtStatus & evtMask);
      end
   end

   // ----------------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------------
   // data stand one cycle only; unmapped indices read zero
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         regRdData <= 8'h00;
      end else if (ce) begin
         if (regRdStb) begin
            unique case (regAddr)
               `SADC_RESULT_IDX:     regRdData <= result;
               `SADC_CSR_IDX:        regRdData <= {coco, 1'b0, converterOn, 1'b0, inputSelect};
               `SADC_EVT_STATUS_IDX: regRdData <= {6'h00, evtStatus};
               `SADC_EVT_MASK_IDX:   regRdData <= {6'h00, evtMask};
               default:              regRdData <= 8'h00;
            endcase
         end else begin
            regRdData <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------------
   // analog-side outputs
   // ----------------------------------------------------------------------
   // power follows the bit except in halt; channel changes apply on the write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         converterPowered <= 1'b0;
         muxSel           <= 4'h0;
      end else if (ce) begin
         if (haltMode) begin
            converterPowered <= 1'b0;
         end else if (wrCsr) begin
            converterPowered <= regWrData[`SADC_CSR_ON_BIT];
         end else begin
            converterPowered <= converterOn;
         end
         if (wrCsr) begin
            muxSel <= regWrData[`SADC_CSR_SEL_MSB:`SADC_CSR_SEL_LSB];
         end
      end
   end

   // the sample switch is the sample-state flop itself
   assign sampleEn = state[1];

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   logic [7:0] smpCycles;
   logic [7:0] cnvCycles;

   // cycle counters seen only by the checks below
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         smpCycles <= 8'h00;
         cnvCycles <= 8'h00;
      end else if (ce) begin
         smpCycles <= (state == SADC_SAMPLE && !wrCsr) ? smpCycles + 8'h01 : 8'h00;
         cnvCycles <= (state == SADC_CONVERT && !wrCsr) ? cnvCycles + 8'h01 : 8'h00;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn || !ce);

   sequence s_restart;
      restartReq && !haltMode;
   endsequence
   sequence s_fresh_sample;
      (state == SADC_SAMPLE) && sampleEn && !coco && (phaseCnt == 4'h0);
   endsequence

   a_tick_spacing : assert property (
      adcTick |-> ##1 !adcTick[*3])
      else $error("conversion period shorter than four clocks");
   a_sample_length : assert property (
      (state == SADC_CONVERT && $past(state) == SADC_SAMPLE) |-> smpCycles == SMP_CYCLES)
      else $error("sample phase length wrong");
   a_convert_length : assert property (
      lastStep |-> cnvCycles == CNV_LAST_CYC)
      else $error("approximation phase length wrong");
   a_cycle_repeats : assert property (
      lastStep |=> (state == SADC_SAMPLE) && sampleEn)
      else $error("sampling did not follow a conversion");
   a_coco_set : assert property (
      lastStep |=> coco && (result == $past(sarResolved)))
      else $error("completion not flagged with the result");
   a_no_done_irq : assert property (
      (lastStep && !coco && !rdStatus) |=> evtStatus == $past(evtStatus))
      else $error("completion raised an event");
   a_result_hold : assert property (
      (result != $past(result)) |-> $past(lastStep))
      else $error("result changed outside a conversion end");
   a_abort_restart : assert property (
      s_restart |=> s_fresh_sample ##1 ((state == SADC_SAMPLE) || $past(wrCsr || haltMode)))
      else $error("control write did not restart sampling");
   a_coco_clear : assert property (
      ((rdResult || wrCsr) && !lastStep) |=> !coco)
      else $error("completion flag not cleared");
   a_off_stops : assert property (
      (wrCsr && !regWrData[`SADC_CSR_ON_BIT]) |=> !sampleEn && !converterPowered
         && state == SADC_OFF)
      else $error("converter still running after off");
   a_mux_follows : assert property (
      wrCsr |=> muxSel == $past(regWrData[3:0]))
      else $error("input select not applied");
   a_halt_off : assert property (
      haltMode |=> !converterPowered && state == SADC_OFF)
      else $error("converter active in halt");
endmodule

// ==== test/sadcb_comp_model.sv ====
// comparator and input multiplexer model facing the sequencer
`timescale 1ns/10ps
module sadcb_comp_model (
   input  wire logic       sys_clk,  // system clock
   input  wire logic       sampleEn, // capacitor tied to input
   input  wire logic [3:0] muxSel,   // selected input
   input  wire logic [7:0] dacCode,  // trial code
   input  wire logic       powered,  // analog part powered
   output logic            compGe    // held level at or above trial
);
   // ----------------------------------------------------------
   // sample capacitor and comparator
   // ----------------------------------------------------------
   logic [7:0] held = 8'h00;
   logic       junk = 1'b0;
   // input n sits at n*17: input 0 on lower, input 15 on upper reference
   always @(posedge sys_clk) begin
      if (sampleEn) begin
         held <= {muxSel, muxSel};
      end
      junk <= ~junk;
   end
   // only the held charge counts; unpowered output wanders, so no stale help
   assign compGe = powered ? (held >= dacCode) : junk;
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`include "sadc_defs.svh"
module testbench;
   // ----------------------------------------------------------
   // stimulus, design and partner
   // ----------------------------------------------------------
   typedef struct {logic [7:0] converter_control_status; logic [7:0] res;} sadcb_row_type;
   logic                    sys_clk   = 1'b0;
   logic                    rstn      = 1'b0;
   logic [`SADC_ADDR_W-1:0] regAddr   = 4'h0;
   logic [7:0]              regWrData = 8'h00;
   logic                    regWrStb  = 1'b0;
   logic                    regRdStb  = 1'b0;
   logic                    haltMode  = 1'b0;
   logic                    ce        = 1'b1;
   logic [7:0]              regRdData, dacCode;
   logic [3:0]              muxSel;
   logic                    compGe, sampleEn, converterPowered, irq;
   int                      err_total   = 0;
   int                      checks_done = 0;
   int                      cyc         = 0;
   // channel n converts to n*17; ends of the scale included
   sadcb_row_type           rows [4] = '{'{8'h20, 8'h00}, '{8'h21, 8'h11},
                                         '{8'h27, 8'h77}, '{8'h2f, 8'hff}};
   always #12.5 sys_clk = ~sys_clk;
   // short stabilisation keeps the halt case brief
   sadc_sequencer #(.STAB_PERIODS(1)) sadc_sequencer_inst (
      .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .compGe(compGe), .haltMode(haltMode),
      .sampleEn(sampleEn), .muxSel(muxSel), .dacCode(dacCode),
      .converterPowered(converterPowered), .irq(irq));
   sadcb_comp_model sadcb_comp_model_inst (
      .sys_clk(sys_clk), .sampleEn(sampleEn), .muxSel(muxSel),
      .dacCode(dacCode), .powered(converterPowered), .compGe(compGe));
   // ----------------------------------------------------------
   // bus tasks and checks
   // ----------------------------------------------------------
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWrStb  <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWrStb  <= 1'b0;
      #1;
   endtask
   // read data stand only in the cycle after the strobe edge
   task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      regRdStb <= 1'b1;
      regAddr  <= a;
      @(posedge sys_clk);
      regRdStb <= 1'b0;
      #1 chk(regRdData, exp);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // hang guard, well above the expected run of about 700 cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         close_out();
      end
   end
   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      idle(12);
      rstn <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         rdchk(4'(i), 8'h00);
      end
      $display("reset test done");
      // write lands at c0; end of conversion sets the flag at c48
      foreach (rows[i]) begin
         wr(`SADC_CSR_IDX, rows[i].converter_control_status);
         chk({7'h00, sampleEn}, 8'h01);
         chk({4'h0, muxSel}, {4'h0, rows[i].converter_control_status[3:0]});
         idle(42);
         rdchk(`SADC_CSR_IDX, rows[i].converter_control_status);
         idle(6);
         rdchk(`SADC_CSR_IDX, rows[i].converter_control_status | 8'h80);
         chk({7'h00, irq}, 8'h00);
         rdchk(`SADC_RESULT_IDX, rows[i].res);
         rdchk(`SADC_CSR_IDX, rows[i].converter_control_status);
         $display("row %0d done", i);
      end
      // abort in mid-conversion, then the next result comes unasked
      wr(`SADC_CSR_IDX, 8'h23);
      idle(20);
      wr(`SADC_CSR_IDX, 8'h27);
      idle(42);
      rdchk(`SADC_CSR_IDX, 8'h27);
      idle(6);
      rdchk(`SADC_CSR_IDX, 8'ha7);
      rdchk(`SADC_RESULT_IDX, 8'h77);
      idle(44);
      rdchk(`SADC_CSR_IDX, 8'ha7);
      $display("abort test done");
      // abort event raises irq only while unmasked
      rdchk(`SADC_EVT_STATUS_IDX, 8'h02);
      wr(`SADC_EVT_MASK_IDX, 8'h03);
      rdchk(`SADC_EVT_MASK_IDX, 8'h03);
      chk({7'h00, irq}, 8'h00);
      wr(`SADC_CSR_IDX, 8'h27);
      idle(2);
      #1 chk({7'h00, irq}, 8'h01);
      rdchk(`SADC_EVT_STATUS_IDX, 8'h02);
      idle(2);
      #1 chk({7'h00, irq}, 8'h00);
      wr(`SADC_EVT_MASK_IDX, 8'h00);
      wr(`SADC_CSR_IDX, 8'h27);
      idle(2);
      #1 chk({7'h00, irq}, 8'h00);
      rdchk(`SADC_EVT_STATUS_IDX, 8'h02);
      $display("interrupt test done");
      // switch off: no further result, old result kept
      wr(`SADC_CSR_IDX, 8'h07);
      chk({6'h00, converterPowered, sampleEn}, 8'h00);
      idle(60);
      rdchk(`SADC_CSR_IDX, 8'h07);
      rdchk(`SADC_RESULT_IDX, 8'h77);
      // unmapped and read-only places ignore writes
      rdchk(4'h9, 8'h00);
      wr(4'h9, 8'hff);
      wr(`SADC_RESULT_IDX, 8'h55);
      rdchk(`SADC_CSR_IDX, 8'h07);
      rdchk(`SADC_RESULT_IDX, 8'h77);
      $display("off and map test done");
      // halt stops the converter, on bit survives, results resume
      wr(`SADC_CSR_IDX, 8'h2f);
      idle(3);
      haltMode <= 1'b1;
      idle(2);
      #1 chk({6'h00, converterPowered, sampleEn}, 8'h00);
      rdchk(`SADC_CSR_IDX, 8'h2f);
      @(posedge sys_clk);
      haltMode <= 1'b0;
      idle(70);
      rdchk(`SADC_CSR_IDX, 8'haf);
      rdchk(`SADC_RESULT_IDX, 8'hff);
      $display("halt test done");
      // freeze mid-conversion: the end must slip by the frozen cycles
      @(posedge sys_clk);
      ce <= 1'b0;
      idle(60);
      ce <= 1'b1;
      rdchk(`SADC_CSR_IDX, 8'h2f);
      idle(30);
      rdchk(`SADC_CSR_IDX, 8'haf);
      $display("clock enable test done");
      // second reset in mid-run
      @(posedge sys_clk);
      rstn <= 1'b0;
      idle(3);
      rstn <= 1'b1;
      rdchk(`SADC_CSR_IDX, 8'h00);
      rdchk(`SADC_RESULT_IDX, 8'h00);
      $display("second reset test done");
      close_out();
   end
endmodule
